// >>> design/usb_function_config.sv
// usb function address, endpoint index and endpoint control registers
`default_nettype none
`include "usb_function_defines.svh"

module usb_function_config
    import usb_function_pkg::*;
(
    input  wire logic        clk_in,             // system clock, 50 MHz
    input  wire logic        rst_n_in,           // sync reset, active low
    // ahb-lite slave
    input  wire logic        hsel_in,            // slave select
    input  wire logic [11:0] haddr_in,           // byte address
    input  wire logic [1:0]  htrans_in,          // transfer type
    input  wire logic        hwrite_in,          // write when high
    input  wire logic [2:0]  hsize_in,           // transfer size
    input  wire logic        hready_in,          // bus ready
    input  wire logic [31:0] hwdata_in,          // write data
    output var  logic [31:0] hrdata_out,         // read data
    output var  logic        hreadyout_out,      // slave ready
    output var  logic        hresp_out,          // response, always okay
    // events from the usb protocol engine, same clock
    input  wire logic        bus_reset_in,       // usb bus reset seen, pulse
    input  wire logic        end_of_reset_in,    // end of bus reset, pulse
    input  wire logic [3:0]  event_ep_in,        // endpoint of the event
    input  wire logic        nak_in_event_in,    // in token got nak, pulse
    input  wire logic        nak_out_event_in,   // out token got nak, pulse
    input  wire logic        data0_rx_in,        // valid data0 received, pulse
    input  wire logic        data1_rx_in,        // valid data1 received, pulse
    // configuration towards the protocol engine
    output var  logic        function_enable_out, // usb function enabled
    output var  logic [6:0]  device_address_out, // device address
    output var  logic [6:0]  ep_enable_out,      // per-endpoint enable
    output var  logic [6:0]  ep_dir_in_out,      // per-endpoint in direction
    output var  logic [13:0] ep_type_out,        // two type bits per endpoint
    output var  logic        irq_out             // level interrupt
);

    localparam int EP_N = `ENDPOINT_COUNT;

    // ****************************************************************
    // state
    // ****************************************************************
    reg_byte_t   global_irq_enable_reg;
    reg_byte_t   function_address_reg;
    logic [3:0]  endpoint_index_reg;
    reg_byte_t   irq_status_reg;
    reg_byte_t   irq_mask_reg;
    logic        irq_reg;
    logic        dp_valid_reg;
    logic        dp_write_reg;
    logic [9:0]  dp_index_reg;
    logic [31:0] hrdata_reg;
    logic        hreadyout_reg;

    reg_byte_t   global_irq_enable_next;
    reg_byte_t   function_address_next;
    logic [3:0]  endpoint_index_next;
    reg_byte_t   irq_status_next;
    reg_byte_t   irq_mask_next;
    logic [31:0] hrdata_next;

    // ****************************************************************
    // ahb-lite address phase
    // ****************************************************************
    // only nonseq/seq with hready high start a transfer
    wire         addr_take   = hsel_in & htrans_in[1] & hready_in;
    wire [9:0]   addr_index  = haddr_in[11:2];

    // data phase write strobes, byte lane zero carries the register
    wire         dp_wr       = dp_valid_reg & dp_write_reg;
    wire [7:0]   wr_byte     = hwdata_in[7:0];
    wire         wr_gie      = dp_wr & (dp_index_reg == `IDX_GLOBAL_IRQ_ENABLE);
    wire         wr_addr     = dp_wr & (dp_index_reg == `IDX_FUNCTION_ADDRESS);
    wire         wr_index    = dp_wr & (dp_index_reg == `IDX_ENDPOINT_INDEX);
    wire         wr_ctrl     = dp_wr & (dp_index_reg == `IDX_ENDPOINT_CONTROL);
    wire         wr_status   = dp_wr & (dp_index_reg == `IDX_IRQ_STATUS);
    wire         wr_mask     = dp_wr & (dp_index_reg == `IDX_IRQ_MASK);

    // ****************************************************************
    // endpoint control copies
    // ****************************************************************
    reg_byte_t   ep_ctrl [EP_N];
    logic [6:0]  ep_nak_event;
    logic [6:0]  ep_enable_w;
    logic [6:0]  ep_dir_w;
    logic [13:0] ep_type_w;

    // index seven and above selects no copy
    wire         index_valid = (endpoint_index_reg < 4'(EP_N));
    wire [2:0]   index_sel   = endpoint_index_reg[2:0];

    genvar g;
    generate
        for (g = 0; g < EP_N; g++) begin : gen_ep
            // writes reach only the copy the index points at
            wire wr_this = wr_ctrl & (endpoint_index_reg == 4'(g));
            wire ev_this = (event_ep_in == 4'(g));

            endpoint_control_slot #(
                .FORCE_CONTROL (g == 0)
            ) u_slot (
                .clk_in         (clk_in),
                .rst_n_in       (rst_n_in),
                .wr_en_in       (wr_this),
                .wr_data_in     (wr_byte),
                .nak_in_set_in  (nak_in_event_in & ev_this),
                .nak_out_set_in (nak_out_event_in & ev_this),
                .data0_rx_in    (data0_rx_in & ev_this),
                .data1_rx_in    (data1_rx_in & ev_this),
                .ctrl_out       (ep_ctrl[g]),
                .dir_in_out     (ep_dir_w[g]),
                .nak_event_out  (ep_nak_event[g])
            );

            assign ep_enable_w[g]        = ep_ctrl[g][`BIT_ENDPOINT_ENABLE];
            assign ep_type_w[2*g+1:2*g]  = ep_ctrl[g][1:0];
        end
    endgenerate

    // ****************************************************************
    // register next values
    // ****************************************************************
    // reserved bits of the global enable stay zero
    assign global_irq_enable_next = wr_gie
        ? (wr_byte & `WMASK_GLOBAL_IRQ_ENABLE) : global_irq_enable_reg;

    // bus reset returns the address field to zero, enable untouched
    always_comb begin
        function_address_next = function_address_reg;
        if (wr_addr) begin
            function_address_next = wr_byte;
        end
        if (bus_reset_in) begin
            function_address_next[6:0] = 7'h00;
        end
    end

    // only the low nibble is stored, upper bits read zero
    assign endpoint_index_next = wr_index ? wr_byte[3:0] : endpoint_index_reg;

    // sticky events: a set in the clearing cycle wins over the clear
    wire [7:0] irq_set = {global_irq_enable_reg[`BIT_END_OF_RESET_IEN] & end_of_reset_in,
                          ep_nak_event};
    wire [7:0] irq_clr = wr_status ? wr_byte : 8'h00;
    assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
    assign irq_mask_next   = wr_mask ? wr_byte : irq_mask_reg;

    // ****************************************************************
    // read data, selected in the address phase
    // ****************************************************************
    wire [7:0] ctrl_read = index_valid ? ep_ctrl[index_sel] : 8'h00;
    wire [7:0] read_byte =
        (addr_index == `IDX_GLOBAL_IRQ_ENABLE) ? global_irq_enable_reg :
        (addr_index == `IDX_FUNCTION_ADDRESS)  ? function_address_reg :
        (addr_index == `IDX_ENDPOINT_INDEX)    ? {4'h0, endpoint_index_reg} :
        (addr_index == `IDX_ENDPOINT_CONTROL)  ? ctrl_read :
        (addr_index == `IDX_IRQ_STATUS)        ? irq_status_reg :
        (addr_index == `IDX_IRQ_MASK)          ? irq_mask_reg :
        8'h00;
    // unmapped addresses read zero; with no wait states a write data phase can overlap
    // a read address phase, and that read then returns the value from before the write
    assign hrdata_next = (addr_take & ~hwrite_in) ? {24'h000000, read_byte} : hrdata_reg;

    // ****************************************************************
    // bus pipeline registers
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            dp_valid_reg  <= 1'b0;
            dp_write_reg  <= 1'b0;
            dp_index_reg  <= 10'h000;
            hrdata_reg    <= 32'h00000000;
            hreadyout_reg <= 1'b1;
        end else begin
            dp_valid_reg  <= addr_take;
            dp_write_reg  <= hwrite_in;
            dp_index_reg  <= addr_index;
            hrdata_reg    <= hrdata_next;
            hreadyout_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // software visible registers
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            global_irq_enable_reg <= `RST_GLOBAL_IRQ_ENABLE;
            function_address_reg  <= `RST_FUNCTION_ADDRESS;
            endpoint_index_reg    <= `RST_ENDPOINT_INDEX;
            irq_status_reg        <= `RST_IRQ_STATUS;
            irq_mask_reg          <= `RST_IRQ_MASK;
        end else begin
            global_irq_enable_reg <= global_irq_enable_next;
            function_address_reg  <= function_address_next;
            endpoint_index_reg    <= endpoint_index_next;
            irq_status_reg        <= irq_status_next;
            irq_mask_reg          <= irq_mask_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // interrupt registered from next values so it tracks status at once
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_next & irq_mask_next);
        end
    end

    assign hrdata_out          = hrdata_reg;
    assign hreadyout_out       = hreadyout_reg;
    assign hresp_out           = 1'b0;   // okay only
    assign function_enable_out = function_address_reg[`BIT_FUNCTION_ENABLE];
    assign device_address_out  = function_address_reg[6:0];
    assign ep_enable_out       = ep_enable_w;
    assign ep_dir_in_out       = ep_dir_w;
    assign ep_type_out         = ep_type_w;
    assign irq_out             = irq_reg;

endmodule : usb_function_config

`default_nettype wire

// >>> shared/usb_function_defines.svh
// register offsets, field positions and reset values of the usb function block
`ifndef USB_FUNCTION_DEFINES_SVH
`define USB_FUNCTION_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_GLOBAL_IRQ_ENABLE   10'h0BE
`define IDX_FUNCTION_ADDRESS    10'h0C6
`define IDX_ENDPOINT_INDEX      10'h0C7
`define IDX_ENDPOINT_CONTROL    10'h0D4
`define IDX_IRQ_STATUS          10'h0F0
`define IDX_IRQ_MASK            10'h0F1

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define RST_GLOBAL_IRQ_ENABLE   8'h10
`define WMASK_GLOBAL_IRQ_ENABLE 8'h39
`define RST_FUNCTION_ADDRESS    8'h00
`define RST_ENDPOINT_INDEX      4'h0
`define RST_ENDPOINT_CONTROL    8'h00
`define RST_IRQ_STATUS          8'h00
`define RST_IRQ_MASK            8'hFF

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_FUNCTION_ENABLE     7
`define BIT_END_OF_RESET_IEN    4
`define BIT_ENDPOINT_ENABLE     7
`define BIT_NAK_IRQ_ENABLE      6
`define BIT_NAK_OUT_FLAG        5
`define BIT_NAK_IN_FLAG         4
`define BIT_DATA_TOGGLE         3
`define BIT_ENDPOINT_DIRECTION  2
`define BIT_STATUS_END_OF_RESET 7
`define ENDPOINT_COUNT          7

`endif

// >>> shared/usb_function_pkg.sv
// types shared by the usb function configuration block
`default_nettype none

package usb_function_pkg;

    // endpoint transfer type encoding
    typedef enum logic [1:0] {
        EP_CONTROL     = 2'h0,
        EP_ISOCHRONOUS = 2'h1,
        EP_BULK        = 2'h2,
        EP_INTERRUPT   = 2'h3
    } ep_type_t;

    typedef logic [7:0] reg_byte_t;

endpackage : usb_function_pkg

`default_nettype wire

// >>> design/endpoint_control_slot.sv
// one endpoint's copy of the indexed endpoint control register
`default_nettype none
`include "usb_function_defines.svh"

module endpoint_control_slot
    import usb_function_pkg::*;
#(
    parameter bit FORCE_CONTROL = 1'b0
) (
    input  wire logic clk_in,          // system clock
    input  wire logic rst_n_in,        // sync reset, active low
    input  wire logic wr_en_in,        // cpu write to this copy
    input  wire logic [7:0] wr_data_in, // cpu write data
    input  wire logic nak_in_set_in,   // in token answered with nak
    input  wire logic nak_out_set_in,  // out token answered with nak
    input  wire logic data0_rx_in,     // valid data0 received
    input  wire logic data1_rx_in,     // valid data1 received
    output var  logic [7:0] ctrl_out,  // register contents
    output var  logic dir_in_out,      // effective direction, high = in
    output logic      nak_event_out    // nak flag set while its interrupt enable is high
);

    reg_byte_t ctrl_reg;
    reg_byte_t ctrl_next;
    logic      dir_in_reg;
    logic      dir_in_next;
    ep_type_t  type_field;
    logic      nak_in_keep;
    logic      nak_out_keep;

    // ****************************************************************
    // next value
    // ****************************************************************
    // software can only clear a nak flag; a set in the same cycle wins
    assign nak_in_keep  = ctrl_reg[`BIT_NAK_IN_FLAG] & ~(wr_en_in & ~wr_data_in[`BIT_NAK_IN_FLAG]);
    assign nak_out_keep = ctrl_reg[`BIT_NAK_OUT_FLAG]
                          & ~(wr_en_in & ~wr_data_in[`BIT_NAK_OUT_FLAG]);
    // endpoint zero is pinned to control whatever is written
    assign type_field = FORCE_CONTROL ? EP_CONTROL
                      : ep_type_t'(wr_en_in ? wr_data_in[1:0] : ctrl_reg[1:0]);

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_en_in) begin
            ctrl_next[`BIT_ENDPOINT_ENABLE]    = wr_data_in[`BIT_ENDPOINT_ENABLE];
            ctrl_next[`BIT_NAK_IRQ_ENABLE]     = wr_data_in[`BIT_NAK_IRQ_ENABLE];
            ctrl_next[`BIT_ENDPOINT_DIRECTION] = wr_data_in[`BIT_ENDPOINT_DIRECTION];
        end
        ctrl_next[`BIT_NAK_IN_FLAG]  = nak_in_keep | nak_in_set_in;
        ctrl_next[`BIT_NAK_OUT_FLAG] = nak_out_keep | nak_out_set_in;
        // toggle status follows the pid of the last valid data packet
        if (data1_rx_in) begin
            ctrl_next[`BIT_DATA_TOGGLE] = 1'b1;
        end else if (data0_rx_in) begin
            ctrl_next[`BIT_DATA_TOGGLE] = 1'b0;
        end
        ctrl_next[1:0] = type_field;
    end

    // direction only counts for non-control endpoints
    assign dir_in_next = ctrl_next[`BIT_ENDPOINT_DIRECTION]
                         & (ctrl_next[1:0] != EP_CONTROL);
    assign nak_event_out = ctrl_reg[`BIT_NAK_IRQ_ENABLE]
                           & (nak_in_set_in | nak_out_set_in);

    // ****************************************************************
    // storage
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_reg   <= `RST_ENDPOINT_CONTROL;
            dir_in_reg <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            dir_in_reg <= dir_in_next;
        end
    end

    assign ctrl_out   = ctrl_reg;
    assign dir_in_out = dir_in_reg;

endmodule : endpoint_control_slot

`default_nettype wire

// >>> tb/usb_function_config_props.sv
// concurrent checks on the ports of the usb function configuration block
`default_nettype none
`include "usb_function_defines.svh"

module usb_function_config_props (
    input wire logic        clk_in,              // clock
    input wire logic        rst_n_in,            // sync reset, low
    input wire logic        hsel_in,             // slave select
    input wire logic [11:0] haddr_in,            // byte address
    input wire logic [1:0]  htrans_in,           // transfer type
    input wire logic        hwrite_in,           // write
    input wire logic        hready_in,           // bus ready
    input wire logic [31:0] hwdata_in,           // write data
    input wire logic [31:0] hrdata_out,          // read data
    input wire logic        bus_reset_in,        // usb bus reset
    input wire logic        function_enable_out, // function on
    input wire logic [6:0]  device_address_out,  // address
    input wire logic [6:0]  ep_enable_out,       // endpoint enables
    input wire logic [6:0]  ep_dir_in_out,       // endpoint directions
    input wire logic [13:0] ep_type_out          // endpoint types
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // helper logic
    // ********************
    wire        take = hsel_in && htrans_in[1] && hready_in;
    wire  [9:0] aidx = haddr_in[11:2];
    logic [6:0] ctl_type;                 // endpoint n is of control type
    logic       idx_wr_reg;               // index write in its data phase
    logic [3:0] sel_reg;                  // index as software left it
    wire        sel_ok = sel_reg != 4'h0 && sel_reg < 4'h7; // endpoint 1 to 6
    // type decode per endpoint
    always_comb begin
        for (int n = 0; n < 7; n++) begin
            ctl_type[n] = ep_type_out[2*n +: 2] == 2'h0;
        end
    end
    // index follows the data phase edge, the same edge the slave uses
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            idx_wr_reg <= 1'b0;
            sel_reg    <= 4'h0;
        end else begin
            idx_wr_reg <= take && hwrite_in && aidx == `IDX_ENDPOINT_INDEX;
            if (idx_wr_reg) begin
                sel_reg <= hwdata_in[3:0];
            end
        end
    end
    // ********************
    // properties
    // ********************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // address phase followed by the data phase of a write
    sequence s_wr(logic [9:0] idx);
        take && hwrite_in && aidx == idx ##1 1'b1;
    endsequence
    property p_fen; s_wr(`IDX_FUNCTION_ADDRESS) |=> function_enable_out == $past(hwdata_in[7]); endproperty
    a_fen: assert property (p_fen) else $error("function enable not loaded");
    property p_addr; s_wr(`IDX_FUNCTION_ADDRESS) |=> device_address_out == $past(hwdata_in[6:0]); endproperty
    a_addr: assert property (p_addr) else $error("device address not loaded");
    property p_bus_rst; bus_reset_in |=> device_address_out == 7'h00; endproperty
    a_bus_rst: assert property (p_bus_rst) else $error("address kept over bus reset");
    property p_ep_en; s_wr(`IDX_ENDPOINT_CONTROL) ##0 sel_reg < 4'h7 |=>
        ep_enable_out[$past(sel_reg)] == $past(hwdata_in[7]); endproperty
    a_ep_en: assert property (p_ep_en) else $error("endpoint enable not loaded");
    property p_ep_iso; s_wr(`IDX_ENDPOINT_CONTROL) |=>
        ((ep_enable_out ^ $past(ep_enable_out)) & ~(7'h01 << $past(sel_reg))) == 7'h00; endproperty
    a_ep_iso: assert property (p_ep_iso) else $error("other endpoint changed");
    property p_dir; s_wr(`IDX_ENDPOINT_CONTROL) ##0 sel_ok && hwdata_in[1:0] != 2'h0 |=>
        ep_dir_in_out[$past(sel_reg)] == $past(hwdata_in[2]); endproperty
    a_dir: assert property (p_dir) else $error("direction not loaded");
    property p_dir_ctl; (ep_dir_in_out & ctl_type) == 7'h00; endproperty
    a_dir_ctl: assert property (p_dir_ctl) else $error("control endpoint has direction");
    property p_ep0; ep_type_out[1:0] == 2'h0; endproperty
    a_ep0: assert property (p_ep0) else $error("endpoint zero not control");
    property p_type; s_wr(`IDX_ENDPOINT_CONTROL) ##0 sel_ok |=>
        ((ep_type_out >> {$past(sel_reg), 1'b0}) & 14'h0003) == {12'h000, $past(hwdata_in[1:0])};
    endproperty
    a_type: assert property (p_type) else $error("type not loaded");
    property p_idx_rd; take && !hwrite_in && aidx == `IDX_ENDPOINT_INDEX |=>
        hrdata_out == {28'h0, $past(sel_reg)}; endproperty
    a_idx_rd: assert property (p_idx_rd) else $error("index read wrong");
endmodule : usb_function_config_props

bind usb_function_config usb_function_config_props props_i (
    .clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hwdata_in,
    .hrdata_out, .bus_reset_in, .function_enable_out, .device_address_out, .ep_enable_out,
    .ep_dir_in_out, .ep_type_out
);

`default_nettype wire

// >>> tb/usb_engine_model.sv
// behavioural usb protocol engine raising reset, nak and data events
`default_nettype none

module usb_engine_model (
    input  wire logic       clk_in,           // clock
    output var  logic       bus_reset_out,    // bus reset pulse
    output var  logic       end_of_reset_out, // end of reset pulse
    output var  logic [3:0] event_ep_out,     // event endpoint
    output var  logic       nak_in_out,       // in token nak pulse
    output var  logic       nak_out_out,      // out token nak pulse
    output var  logic       data0_out,        // valid data0 pulse
    output var  logic       data1_out         // valid data1 pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] pulse_reg = 6'h00;            // one bit per event kind
    assign {bus_reset_out, end_of_reset_out, nak_in_out} = pulse_reg[5:3];
    assign {nak_out_out, data0_out, data1_out} = pulse_reg[2:0];
    initial event_ep_out = 4'hF;
    // one-cycle event; endpoint lines inverted while idle so no stale value helps
    task automatic fire(input int kind, input logic [3:0] ep);
        @(posedge clk_in);
        pulse_reg    <= 6'(6'h20 >> kind);
        event_ep_out <= ep;
        @(posedge clk_in);
        pulse_reg    <= 6'h00;
        event_ep_out <= ~ep;
    endtask : fire
endmodule : usb_engine_model

`default_nettype wire

// >>> tb/test_usb_function_config.sv
// self-checking bench for the usb function configuration block
`default_nettype none
`include "usb_function_defines.svh"

module test_usb_function_config;
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // signals and instances
    // ********************
    localparam logic [9:0] GIE = `IDX_GLOBAL_IRQ_ENABLE, FAD = `IDX_FUNCTION_ADDRESS,
        EPI = `IDX_ENDPOINT_INDEX, EPC = `IDX_ENDPOINT_CONTROL,
        IST = `IDX_IRQ_STATUS, IMK = `IDX_IRQ_MASK;
    logic        clk_in, rst_n_in, hsel_in, hwrite_in, hreadyout_out, hresp_out, irq_out;
    logic        bus_reset_in, end_of_reset_in, nak_in_event_in, nak_out_event_in;
    logic        data0_rx_in, data1_rx_in, function_enable_out;
    logic [1:0]  htrans_in;
    logic [3:0]  event_ep_in;
    logic [11:0] haddr_in;
    logic [31:0] hwdata_in, hrdata_out, rd_val;
    logic [6:0]  device_address_out, ep_enable_out, ep_dir_in_out, exp_dir;
    logic [13:0] ep_type_out, exp_type;
    int          fail_count = 0, check_count = 0;
    usb_function_config usb_function_config_i (.clk_in, .rst_n_in, .hsel_in, .haddr_in,
        .htrans_in, .hwrite_in, .hsize_in(3'h2), .hready_in(hreadyout_out), .hwdata_in,
        .hrdata_out, .hreadyout_out, .hresp_out, .bus_reset_in, .end_of_reset_in,
        .event_ep_in, .nak_in_event_in, .nak_out_event_in, .data0_rx_in, .data1_rx_in,
        .function_enable_out, .device_address_out, .ep_enable_out, .ep_dir_in_out,
        .ep_type_out, .irq_out);
    usb_engine_model usb_engine_model_i (.clk_in, .bus_reset_out(bus_reset_in),
        .end_of_reset_out(end_of_reset_in), .event_ep_out(event_ep_in),
        .nak_in_out(nak_in_event_in), .nak_out_out(nak_out_event_in),
        .data0_out(data0_rx_in), .data1_out(data1_rx_in));
    // ********************
    // tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // single word transfer; each phase held until hready is sampled high
    task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge clk_in);
        hsel_in   <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        haddr_in  <= {idx, 2'h0};
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        hsel_in   <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= {24'h0, wd};
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd_val = hrdata_out;
    endtask : xfer
    task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rd_val, {24'h0, exp});
        chk(32'(hresp_out), 32'h0);
    endtask : rchk
    // outputs are registered, so let their edge pass before looking
    task automatic settle;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : settle
    task automatic do_reset;
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
    endtask : do_reset
    task automatic conclude;
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    // ********************
    // clock, watchdog and tests
    // ********************
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // the tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_in);
        fail_count++;
        conclude();
    end
    initial begin
        hsel_in   <= 1'b0;
        htrans_in <= 2'h0;
        hwrite_in <= 1'b0;
        haddr_in  <= 12'h000;
        hwdata_in <= 32'h0;
        do_reset();
        rchk(GIE, 8'h10);
        rchk(FAD, 8'h00);
        rchk(EPI, 8'h00);
        xfer(1'b1, FAD, 8'hAA);
        settle();
        chk(32'(function_enable_out), 32'h1);
        usb_engine_model_i.fire(0, 4'h0);
        rchk(FAD, 8'h80);
        xfer(1'b1, FAD, 8'h05);
        settle();
        chk(32'(function_enable_out), 32'h0);
        chk(32'(device_address_out), 32'h05);
        // every endpoint once, with the four types in turn; endpoint zero asks for interrupt
        exp_dir  = 7'h00;
        exp_type = 14'h0000;
        for (int e = 0; e < 7; e++) begin
            xfer(1'b1, EPI, 8'(e));
            xfer(1'b1, EPC, (e == 0) ? 8'h87 : 8'h84 | 8'(e % 4));
            if (e % 4 != 0) begin
                exp_dir[e]         = 1'b1;
                exp_type[2*e +: 2] = 2'(e % 4);
            end
        end
        rchk(EPI, 8'h06);
        settle();
        chk(32'(ep_enable_out), 32'h7F);
        chk(32'(ep_dir_in_out), 32'(exp_dir));
        chk(32'(ep_type_out), 32'(exp_type));
        for (int e = 0; e < 7; e++) begin
            xfer(1'b1, EPI, 8'(e));
            rchk(EPC, 8'h84 | 8'(e % 4));
        end
        xfer(1'b1, EPI, 8'h03);
        xfer(1'b1, EPC, 8'h03);
        exp_dir[3] = 1'b0;
        settle();
        chk(32'(ep_enable_out), 32'h77);
        chk(32'(ep_dir_in_out), 32'(exp_dir));
        // nak flags, status, mask and level interrupt
        xfer(1'b1, EPI, 8'h02);
        xfer(1'b1, EPC, 8'hC6);
        usb_engine_model_i.fire(2, 4'h2);
        rchk(EPC, 8'hD6);
        rchk(IST, 8'h04);
        chk(32'(irq_out), 32'h1);
        xfer(1'b1, IMK, 8'hFB);
        settle();
        chk(32'(irq_out), 32'h0);
        xfer(1'b1, IMK, 8'hFF);
        settle();
        chk(32'(irq_out), 32'h1);
        xfer(1'b1, IST, 8'h04);
        xfer(1'b1, EPC, 8'hC6);
        rchk(EPC, 8'hC6);
        chk(32'(irq_out), 32'h0);
        xfer(1'b1, EPI, 8'h01);
        usb_engine_model_i.fire(3, 4'h1);
        rchk(EPC, 8'hA5);
        rchk(IST, 8'h00);
        // data toggle follows the last valid data packet of its endpoint
        usb_engine_model_i.fire(5, 4'h1);
        rchk(EPC, 8'hAD);
        usb_engine_model_i.fire(4, 4'h1);
        rchk(EPC, 8'hA5);
        usb_engine_model_i.fire(5, 4'h2);
        rchk(EPC, 8'hA5);
        // end of reset interrupt, then with its enable cleared
        usb_engine_model_i.fire(1, 4'h0);
        rchk(IST, 8'h80);
        chk(32'(irq_out), 32'h1);
        xfer(1'b1, IST, 8'h80);
        xfer(1'b1, GIE, 8'h00);
        usb_engine_model_i.fire(1, 4'h0);
        rchk(IST, 8'h00);
        chk(32'(irq_out), 32'h0);
        xfer(1'b1, 10'h3FF, 8'h5A);
        rchk(10'h3FF, 8'h00);
        // reset again in mid-run
        do_reset();
        rchk(GIE, 8'h10);
        rchk(FAD, 8'h00);
        chk(32'(ep_enable_out), 32'h00);
        conclude();
    end
endmodule : test_usb_function_config

`default_nettype wire
